// *** speed_limit_pkg.sv ***
// Operation
// - The block enters limited-speed operation as soon as the failsafe input or the fieldbus select asks for it.
// - While limited-speed operation runs and its reduction time has run out, the speed magnitude is compared with the active limit.
// - With the ramp link enabled the speed setpoint is clamped below the active threshold, otherwise it passes unchanged.
// - The setpoint limit of limited-speed operation is handed out to the higher-level controller.
// - Software can make that limit the maximum speed of the ramp generator.
// - Brake-ramp supervision can be enabled only without an encoder and never with one.
// - Deselecting limited-speed operation stops both limiting and monitoring.
// - While active, one of four speed levels is applied, and without selection only a single limit exists.
// - Configured without selection, the function is active from reset onward with no select signal.
// - A switch to a higher speed level is monitored against the higher limit at once.
// - The speed monitor has no external select and works exactly when its threshold is above zero.
// - The speed monitor reports when the speed magnitude is below its threshold.
// - The speed monitor output has a hysteresis so it does not toggle near the threshold.
// - A speed monitor violation only changes its status and never starts a stop response.
`default_nettype none
package speed_limit_pkg;
  localparam int CLK_PERIOD_NS  = 100;
  localparam int REDUCE_TIME_US = 100000;
  localparam int REDUCE_CYCLES  = (REDUCE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int SPEED_W    = 16;
  localparam int NUM_LEVELS = 4;
  localparam int LEVEL_W    = 2;
  localparam int ADDR_W     = 12;

  localparam logic [ADDR_W-1:0] CTRL_OFF       = 12'h000;
  localparam logic [ADDR_W-1:0] LIMIT0_OFF     = 12'h004;
  localparam logic [ADDR_W-1:0] LIMIT_STRIDE   = 12'h004;
  localparam logic [ADDR_W-1:0] MON_LIMIT_OFF  = 12'h014;
  localparam logic [ADDR_W-1:0] MON_HYST_OFF   = 12'h018;
  localparam logic [ADDR_W-1:0] MARGIN_OFF     = 12'h01C;
  localparam logic [ADDR_W-1:0] STATUS_OFF     = 12'h020;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_OFF = 12'h024;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFF   = 12'h028;

  localparam int CTRL_W         = 4;
  localparam int CTRL_SELECT    = 0;
  localparam int CTRL_RAMP_LINK = 1;
  localparam int CTRL_ENCODER   = 2;
  localparam int CTRL_BRAKE     = 3;
  localparam int CTRL_CLEAR     = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;

  localparam int ST_ACTIVE = 0;
  localparam int ST_BELOW  = 1;
  localparam int ST_FAULT  = 2;
  localparam int ST_STOP   = 3;
  localparam int ST_LEVEL  = 4;

  localparam int EV_W         = 4;
  localparam int EV_FAULT     = 0;
  localparam int EV_BELOW_SET = 1;
  localparam int EV_BELOW_CLR = 2;
  localparam int EV_ACTIVE    = 3;
  localparam logic [EV_W-1:0] IRQ_MASK_RST = 4'h0;

  localparam logic [SPEED_W-1:0] LIMIT_RST     = 16'h0100;
  localparam logic [SPEED_W-1:0] MON_LIMIT_RST = 16'h0000;
  localparam logic [SPEED_W-1:0] MON_HYST_RST  = 16'h0010;
  localparam logic [SPEED_W-1:0] MARGIN_RST    = 16'h0001;
endpackage
`default_nettype wire

// *** speed_shaper.sv ***
`default_nettype none
module speed_shaper
  import speed_limit_pkg::*;
#(
  parameter int W = SPEED_W
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic signed [W-1:0] speed_actual,
  input  wire logic signed [W-1:0] speed_setpoint,
  input  wire logic                clamp_en,
  input  wire logic        [W-1:0] clamp_lim,
  output logic             [W-1:0] actual_mag,
  output logic signed      [W-1:0] setpoint_out
);
  localparam logic [W-1:0] MAX_POS = {1'b0, {(W-1){1'b1}}};

  function automatic logic [W-1:0] magnitude(input logic [W-1:0] v);
    return v[W-1] ? W'(~v + 1'b1) : v;
  endfunction

  logic [W-1:0] lim_eff;
  assign lim_eff = (clamp_lim > MAX_POS) ? MAX_POS : clamp_lim;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      actual_mag <= '0;
    end else begin
      actual_mag <= magnitude(speed_actual);
    end
  end

  // sign is kept so the clamp never turns the drive around
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setpoint_out <= '0;
    end else if (clamp_en && magnitude(speed_setpoint) > lim_eff) begin
      setpoint_out <= speed_setpoint[W-1] ? W'(~lim_eff + 1'b1) : lim_eff;
    end else begin
      setpoint_out <= speed_setpoint;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_clamp_bound: assert property (
    clamp_en |=> magnitude(setpoint_out) <= $past(lim_eff))
    else $error("clamped setpoint above limit");
  a_clamp_pass: assert property (
    !clamp_en |=> setpoint_out == $past(speed_setpoint))
    else $error("setpoint altered without ramp link");
endmodule
`default_nettype wire

// *** safe_speed_limit_monitor.sv ***
// Our own choices: the APB register port and the register offsets.
`default_nettype none
module safe_speed_limit_monitor
  import speed_limit_pkg::*;
#(
  parameter int W            = SPEED_W,
  parameter int REDUCE_COUNT = REDUCE_CYCLES
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                failsafe_select,
  input  wire logic                bus_select,
  input  wire logic [LEVEL_W-1:0]  speed_level_select,
  input  wire logic signed [W-1:0] speed_actual,
  input  wire logic signed [W-1:0] speed_setpoint,
  output logic signed      [W-1:0] setpoint_limited,
  output logic             [W-1:0] setpoint_limit,
  output logic             [W-1:0] ramp_max_speed,
  output logic                     limited_speed_function,
  output logic      [LEVEL_W-1:0]  active_level,
  output logic                     speed_below_monitor,
  output logic                     limit_fault,
  output logic                     stop_request,
  output logic                     irq
);
  localparam int TW = $clog2(REDUCE_COUNT + 1);
  localparam logic [TW-1:0] GRACE_LOAD = TW'(REDUCE_COUNT);

  if (W < 8 || W > 32 || REDUCE_COUNT < 1) begin : g_check
    $error("speed width must be 8..32 and reduce count at least 1");
  end

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_LEVELS; i++) begin
      if (a == ADDR_W'(LIMIT0_OFF + LIMIT_STRIDE * i)) begin
        hit = 1'b1;
      end
    end
    unique case (a)
      CTRL_OFF, MON_LIMIT_OFF, MON_HYST_OFF, MARGIN_OFF,
      STATUS_OFF, IRQ_STATUS_OFF, IRQ_MASK_OFF: hit = 1'b1;
      default: ;
    endcase
    return hit;
  endfunction

  logic [CTRL_W-1:0]   ctrl;
  logic [W-1:0]        level_limit [NUM_LEVELS];
  logic [W-1:0]        mon_limit;
  logic [W-1:0]        mon_hyst;
  logic [W-1:0]        margin;
  logic [EV_W-1:0]     irq_status;
  logic [EV_W-1:0]     irq_mask;
  logic [EV_W-1:0]     events;
  logic [TW-1:0]       grace;
  logic [W-1:0]        start_mag;
  logic [W-1:0]        actual_mag;
  logic [W-1:0]        cur_limit;
  logic [W-1:0]        clamp_lim;
  logic [W-1:0]        low_thr;
  logic [LEVEL_W-1:0]  cur_level;
  logic [LEVEL_W-1:0]  next_level;
  logic [31:0]         rd_mux;
  logic                next_active;
  logic                next_below;
  logic                load_grace;
  logic                excess;
  logic                brake_ramp_check;
  logic                brake_viol;
  logic                mon_on;
  logic                setup;
  logic                wr_en;
  logic                fault_clear;
  logic                sel_mode;
  logic                ramp_link;
  logic                clamp_en;

  assign setup       = psel & ~penable;
  assign wr_en       = psel & penable & pready & pwrite;
  assign fault_clear = wr_en && paddr == CTRL_OFF && pwdata[CTRL_CLEAR];
  assign sel_mode    = ctrl[CTRL_SELECT];
  assign ramp_link   = ctrl[CTRL_RAMP_LINK];
  assign clamp_en    = limited_speed_function & ramp_link;

  // apb: zero wait state, answer registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~addr_mapped(paddr);
      if (setup) begin
        prdata <= (pwrite || !addr_mapped(paddr)) ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  always_comb begin
    rd_mux = '0;
    unique case (paddr)
      CTRL_OFF:       rd_mux = 32'(ctrl);
      MON_LIMIT_OFF:  rd_mux = 32'(mon_limit);
      MON_HYST_OFF:   rd_mux = 32'(mon_hyst);
      MARGIN_OFF:     rd_mux = 32'(margin);
      STATUS_OFF:     rd_mux = 32'({cur_level, stop_request, limit_fault,
                                    speed_below_monitor, limited_speed_function});
      IRQ_STATUS_OFF: rd_mux = 32'(irq_status);
      IRQ_MASK_OFF:   rd_mux = 32'(irq_mask);
      default: ;
    endcase
    for (int i = 0; i < NUM_LEVELS; i++) begin
      if (paddr == ADDR_W'(LIMIT0_OFF + LIMIT_STRIDE * i)) begin
        rd_mux = 32'(level_limit[i]);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl      <= CTRL_RST;
      mon_limit <= MON_LIMIT_RST;
      mon_hyst  <= MON_HYST_RST;
      margin    <= MARGIN_RST;
      irq_mask  <= IRQ_MASK_RST;
    end else if (wr_en) begin
      unique case (paddr)
        CTRL_OFF:      ctrl      <= pwdata[CTRL_W-1:0];
        MON_LIMIT_OFF: mon_limit <= pwdata[W-1:0];
        MON_HYST_OFF:  mon_hyst  <= pwdata[W-1:0];
        MARGIN_OFF:    margin    <= pwdata[W-1:0];
        IRQ_MASK_OFF:  irq_mask  <= pwdata[EV_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_LEVELS; i++) begin
        level_limit[i] <= LIMIT_RST;
      end
    end else begin
      for (int i = 0; i < NUM_LEVELS; i++) begin
        if (wr_en && paddr == ADDR_W'(LIMIT0_OFF + LIMIT_STRIDE * i)) begin
          level_limit[i] <= pwdata[W-1:0];
        end
      end
    end
  end

  // selection: without selection the function is always on, level 0 only
  assign next_active = sel_mode ? (failsafe_select | bus_select) : 1'b1;
  assign next_level  = sel_mode ? speed_level_select : '0;
  assign cur_limit   = level_limit[cur_level];
  // only a fresh start or a lower limit gets reduction time; a higher one applies at once
  assign load_grace  = next_active &&
                       (!limited_speed_function || level_limit[next_level] < cur_limit);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limited_speed_function <= 1'b0;
      cur_level              <= '0;
    end else begin
      limited_speed_function <= next_active;
      cur_level              <= next_active ? next_level : '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grace     <= '0;
      start_mag <= '0;
    end else if (!next_active) begin
      grace <= '0;
    end else if (load_grace) begin
      grace     <= GRACE_LOAD;
      start_mag <= actual_mag;
    end else if (grace != '0) begin
      grace <= grace - 1'b1;
    end
  end

  // brake supervision only makes sense on the open-loop speed estimate
  assign brake_ramp_check = ctrl[CTRL_BRAKE] & ~ctrl[CTRL_ENCODER];
  assign brake_viol = limited_speed_function && grace != '0 && brake_ramp_check &&
                      actual_mag > start_mag;
  assign excess     = limited_speed_function && grace == '0 && actual_mag > cur_limit;

  // stop is latched until software clears it; a new violation wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit_fault  <= 1'b0;
      stop_request <= 1'b0;
    end else begin
      limit_fault  <= excess | brake_viol;
      stop_request <= excess | brake_viol | (stop_request & ~fault_clear);
    end
  end

  // speed monitor: independent of selection and of the stop path
  assign mon_on  = mon_limit != '0;
  assign low_thr = (mon_hyst >= mon_limit) ? '0 : W'(mon_limit - mon_hyst);

  always_comb begin
    next_below = speed_below_monitor;
    if (!mon_on) begin
      next_below = 1'b0;
    end else if (actual_mag < low_thr) begin
      next_below = 1'b1;
    end else if (actual_mag > mon_limit) begin
      next_below = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_below_monitor <= 1'b0;
    end else begin
      speed_below_monitor <= next_below;
    end
  end

  // a margin of zero is taken as one so the clamp never sits on the trip point
  assign clamp_lim = (cur_limit > margin) ?
                     W'(cur_limit - margin - W'(margin == '0)) : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setpoint_limit <= '0;
      ramp_max_speed <= '1;
      active_level   <= '0;
    end else begin
      setpoint_limit <= limited_speed_function ? clamp_lim : '0;
      ramp_max_speed <= clamp_en ? clamp_lim : '1;
      active_level   <= cur_level;
    end
  end

  speed_shaper #(
    .W (W)
  ) u_shaper (
    .pclk           (pclk),
    .presetn        (presetn),
    .speed_actual   (speed_actual),
    .speed_setpoint (speed_setpoint),
    .clamp_en       (clamp_en),
    .clamp_lim      (clamp_lim),
    .actual_mag     (actual_mag),
    .setpoint_out   (setpoint_limited)
  );

  always_comb begin
    events               = '0;
    events[EV_FAULT]     = (excess | brake_viol) & ~limit_fault;
    events[EV_BELOW_SET] = next_below & ~speed_below_monitor;
    events[EV_BELOW_CLR] = ~next_below & speed_below_monitor;
    events[EV_ACTIVE]    = next_active ^ limited_speed_function;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= '0;
      irq        <= 1'b0;
    end else begin
      if (wr_en && paddr == IRQ_STATUS_OFF) begin
        irq_status <= (irq_status & ~pwdata[EV_W-1:0]) | events;
      end else begin
        irq_status <= irq_status | events;
      end
      irq <= |(irq_status & irq_mask);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_select;
    sel_mode && (failsafe_select || bus_select);
  endsequence
  sequence s_raise;
    limited_speed_function && next_active && grace == '0 &&
    level_limit[next_level] >= cur_limit;
  endsequence

  a_select_starts: assert property (
    s_select |=> limited_speed_function)
    else $error("selection did not start limiting");
  a_deselect_stops: assert property (
    sel_mode && !failsafe_select && !bus_select |=> !limited_speed_function ##1 !limit_fault)
    else $error("deselect did not stop limiting");
  a_no_select_on: assert property (
    !sel_mode |=> limited_speed_function && cur_level == '0)
    else $error("function off without selection");
  a_level_follows: assert property (
    s_select |=> cur_level == $past(speed_level_select))
    else $error("level not applied");
  a_raise_at_once: assert property (
    s_raise |=> grace == '0)
    else $error("higher level delayed");
  a_excess_stops: assert property (
    excess |=> limit_fault && stop_request)
    else $error("overspeed without stop");
  a_brake_encoder: assert property (
    ctrl[CTRL_ENCODER] |-> !brake_ramp_check)
    else $error("brake check with encoder");
  a_stop_cause: assert property (
    $rose(stop_request) |-> $past(excess || brake_viol))
    else $error("stop without limit violation");
  a_monitor_off: assert property (
    !mon_on |=> !speed_below_monitor)
    else $error("monitor active at zero threshold");
  a_monitor_enter: assert property (
    mon_on && actual_mag < low_thr |=> speed_below_monitor)
    else $error("monitor did not report below");
  a_monitor_hold: assert property (
    mon_on && actual_mag >= low_thr && actual_mag <= mon_limit
    |=> speed_below_monitor == $past(speed_below_monitor))
    else $error("monitor toggled inside hysteresis");
  a_monitor_leave: assert property (
    mon_on && actual_mag > mon_limit |=> !speed_below_monitor)
    else $error("monitor reports below above threshold");
  a_limit_export: assert property (
    limited_speed_function |=> setpoint_limit == $past(clamp_lim))
    else $error("exported limit wrong");
endmodule
`default_nettype wire

// *** speed_ctrl_model.sv ***
`default_nettype none
module speed_ctrl_model
  import speed_limit_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic [1:0]           cmd_sel,
  input  wire logic [LEVEL_W-1:0]   cmd_level,
  input  wire logic [SPEED_W-1:0]   cmd_speed,
  input  wire logic [SPEED_W-1:0]   cmd_setp,
  output logic                      failsafe_select,
  output logic                      bus_select,
  output logic [LEVEL_W-1:0]        speed_level_select,
  output logic signed [SPEED_W-1:0] speed_actual,
  output logic signed [SPEED_W-1:0] speed_setpoint
);
  timeunit 1ns;
  timeprecision 1ns;

  // selects move only on a clock edge, as a cyclic safety telegram would
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      failsafe_select    <= 1'b0;
      bus_select         <= 1'b0;
      speed_level_select <= '0;
    end else begin
      failsafe_select    <= cmd_sel[0];
      bus_select         <= cmd_sel[1];
      speed_level_select <= cmd_level;
    end
  end

  // measurement and setpoint arrive one cycle late, like a sampled encoder path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_actual   <= '0;
      speed_setpoint <= '0;
    end else begin
      speed_actual   <= cmd_speed;
      speed_setpoint <= cmd_setp;
    end
  end
endmodule
`default_nettype wire

// *** safe_speed_limit_monitor_bench.sv ***
`default_nettype none
module safe_speed_limit_monitor_bench
  import speed_limit_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RC = 10;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic fss, bss, limited_speed_function, speed_below_monitor, limit_fault, stop_request, irq;
  logic        [ADDR_W-1:0]  paddr;
  logic        [31:0]        pwdata, prdata, rd;
  logic        [1:0]         sel;
  logic        [LEVEL_W-1:0] lvl, lsel, active_level;
  logic        [SPEED_W-1:0] spd, setp, setpoint_limit, ramp_max_speed;
  logic signed [SPEED_W-1:0] sact, sset, setpoint_limited;
  logic        [SPEED_W-1:0] mon_spd [5] = '{16'h0060, 16'h0078, 16'h0090, 16'h0078, 16'hFFA0};
  logic        [0:4]         mon_exp = 5'b11001;
  logic        [31:0]        lim [4] = '{32'h100, 32'h200, 32'h300, 32'h080};
  int                        err_total, n_compared, cycles;

  safe_speed_limit_monitor #(.W(SPEED_W), .REDUCE_COUNT(RC)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .failsafe_select(fss), .bus_select(bss), .speed_level_select(lsel),
    .speed_actual(sact), .speed_setpoint(sset), .setpoint_limited(setpoint_limited),
    .setpoint_limit(setpoint_limit), .ramp_max_speed(ramp_max_speed),
    .limited_speed_function(limited_speed_function), .active_level(active_level),
    .speed_below_monitor(speed_below_monitor), .limit_fault(limit_fault),
    .stop_request(stop_request), .irq(irq)
  );

  speed_ctrl_model u_ctrl (
    .pclk(pclk), .presetn(presetn), .cmd_sel(sel), .cmd_level(lvl), .cmd_speed(spd),
    .cmd_setp(setp), .failsafe_select(fss), .bus_select(bss), .speed_level_select(lsel),
    .speed_actual(sact), .speed_setpoint(sset)
  );

  always #50 pclk = ~pclk;

  task automatic print_verdict();
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // a stuck design must still end the run with a verdict
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      $display("[ERR] %0t run timed out", $time);
      err_total++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the bench timeout ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // activation with speed already over the limit, then a further rise inside the grace time
  task automatic grace_run(input logic [31:0] ctrl, input logic fault_exp);
    sel <= 2'b00;
    spd <= 16'h0150;
    wr(CTRL_OFF, ctrl);
    tick(3);
    sel <= 2'b01;
    tick(3);
    spd <= 16'h0160;
    tick(5);
    chk(limit_fault, fault_exp);
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    sel = '0;
    lvl = '0;
    spd = '0;
    setp = '0;
    err_total = 0;
    n_compared = 0;
    tick(3);
    presetn <= 1'b1;
    tick(RC + 5);
    rdc(CTRL_OFF, 32'h0);
    for (int i = 0; i < NUM_LEVELS; i++) rdc(LIMIT0_OFF + LIMIT_STRIDE * ADDR_W'(i), 32'h100);
    rdc(MON_LIMIT_OFF, 32'h0);
    rdc(MON_HYST_OFF, 32'h10);
    rdc(MARGIN_OFF, 32'h1);
    rdc(IRQ_MASK_OFF, 32'h0);
    rdc(12'h02C, 32'h0);
    chk(er, 1'b1);
    chk(limited_speed_function, 1'b1);
    chk(setpoint_limit, 32'hFF);
    chk(ramp_max_speed, 32'hFFFF);
    chk(speed_below_monitor, 1'b0);
    lvl <= 2'd3;
    setp <= 16'h0200;
    tick(5);
    chk(active_level, 32'h0);
    chk({16'h0, setpoint_limited}, 32'h200);
    rdc(STATUS_OFF, 32'h1);
    spd <= 16'hFEE0;
    tick(5);
    chk(limit_fault, 1'b1);
    chk(stop_request, 1'b1);
    chk(irq, 1'b0);
    wr(IRQ_MASK_OFF, 32'h1);
    tick(2);
    chk(irq, 1'b1);
    spd <= 16'h0080;
    tick(5);
    chk(limit_fault, 1'b0);
    chk(stop_request, 1'b1);
    wr(IRQ_STATUS_OFF, 32'hF);
    tick(2);
    chk(irq, 1'b0);
    wr(CTRL_OFF, 32'h1E);
    rdc(CTRL_OFF, 32'hE);
    chk(stop_request, 1'b0);
    chk(ramp_max_speed, 32'hFF);
    chk({16'h0, setpoint_limited}, 32'hFF);
    setp <= 16'hFE00;
    tick(3);
    chk({16'h0, setpoint_limited}, 32'hFF01);
    wr(MON_LIMIT_OFF, 32'h80);
    for (int i = 0; i < 5; i++) begin
      spd <= mon_spd[i];
      tick(5);
      chk(speed_below_monitor, mon_exp[i]);
    end
    chk(stop_request, 1'b0);
    rdc(IRQ_STATUS_OFF, 32'h6);
    wr(MON_LIMIT_OFF, 32'h0);
    tick(3);
    chk(speed_below_monitor, 1'b0);
    wr(CTRL_OFF, 32'h3);
    spd <= 16'h0200;
    tick(5);
    chk(limited_speed_function, 1'b0);
    chk(limit_fault, 1'b0);
    chk(ramp_max_speed, 32'hFFFF);
    for (int i = 0; i < NUM_LEVELS; i++) wr(LIMIT0_OFF + LIMIT_STRIDE * ADDR_W'(i), lim[i]);
    spd <= 16'h0;
    sel <= 2'b10;
    tick(4);
    chk(limited_speed_function, 1'b1);
    sel <= 2'b01;
    for (int i = 0; i < NUM_LEVELS; i++) begin
      lvl <= LEVEL_W'(i);
      tick(5);
      chk(active_level, 32'(i));
      chk(setpoint_limit, lim[i] - 32'h1);
    end
    lvl <= 2'd0;
    tick(RC + 5);
    lvl <= 2'd1;
    tick(4);
    spd <= 16'h0180;
    tick(5);
    chk(limit_fault, 1'b0);
    spd <= 16'h0250;
    tick(4);
    chk(limit_fault, 1'b1);
    lvl <= 2'd0;
    grace_run(32'h1D, 1'b0);
    tick(RC);
    chk(limit_fault, 1'b1);
    grace_run(32'h19, 1'b1);
    print_verdict();
  end
endmodule
`default_nettype wire
